// file: logic/smpg_consts.vh
`ifndef SMPG_CONSTS_VH
`define SMPG_CONSTS_VH
// Register indices; byte address is four times the index
`define SMPG_IDX_MODE 8'h00
`define SMPG_IDX_PULSE_FMT 8'h02
`define SMPG_IDX_GEAR_NUM1 8'h12
`define SMPG_IDX_GEAR_DEN 8'h14
`define SMPG_IDX_SPD_CMD1 8'h20
`define SMPG_IDX_TRQ_CMD1 8'h24
`define SMPG_IDX_GEAR_NUM2 8'h30
`define SMPG_IDX_SMOOTH 8'h34
`define SMPG_IDX_DI_ASSIGN 8'h35
`define SMPG_IDX_STATUS 8'h38
`define SMPG_IDX_POS_CMD 8'h39
// Reset values
`define SMPG_RST_MODE 4'h0
`define SMPG_RST_PULSE_FMT 16'h0002
`define SMPG_RST_GEAR 32'h00000001
`define SMPG_RST_SMOOTH 4'h0
`define SMPG_RST_DI_ASSIGN 3'h0
// Limits
`define SMPG_PULSE_FMT_MAX 16'h1142
`define SMPG_GEAR_NUM_MAX 32'h03FFFFFF
`define SMPG_GEAR_DEN_MAX 32'h7FFFFFFF
// Pulse format fields
`define SMPG_FMT_TYPE_LSB 0
`define SMPG_FMT_FILT_LSB 4
`define SMPG_FMT_LOGIC_BIT 8
`define SMPG_FMT_SRC_BIT 12
`define SMPG_PTYPE_QUAD 4'h0
`define SMPG_PTYPE_CWCCW 4'h1
`define SMPG_PTYPE_PDIR 4'h2
// Mode numbers
`define SMPG_MODE_POS 4'h0
`define SMPG_MODE_SPD 4'h1
`define SMPG_MODE_TRQ 4'h2
`define SMPG_MODE_PS 4'h5
`define SMPG_MODE_PT 4'h6
`define SMPG_MODE_ST 4'h7
`define SMPG_MODE_SPD_INT 4'h8
`define SMPG_MODE_TRQ_INT 4'h9
`define SMPG_MODE_SEQ 4'hA
// Timing: highest pulse rate and the clock
`define SMPG_CLK_HZ 50000000
`define SMPG_PULSE_MAX_PPS 4000000
`define SMPG_PULSE_MIN_CYC (`SMPG_CLK_HZ / `SMPG_PULSE_MAX_PPS)
`endif

// file: logic/smpg_gear_scale.v
`timescale 1ns/1ns
`default_nettype none
module smpg_gear_scale (
  // Clock and control
  input wire core_clk,
  input wire rstn,
  input wire clkEn,
  // Steps and ratio
  input wire stepValid,
  input wire stepDir,
  input wire [31:0] numer,
  input wire [31:0] denom,
  // Scaled command position
  output reg [31:0] cmdPos
);
  reg signed [63:0] acc_r;
  reg [63:0] dvd_r;
  reg [63:0] quo_r;
  reg [32:0] rem_r;
  reg neg_r;
  reg [6:0] bit_r;
  wire [32:0] remSh = {rem_r[31:0], dvd_r[63]};
  wire remGe = remSh >= {1'b0, denom};
  wire [63:0] quoDone = {quo_r[62:0], remGe};
  ////////////////////////////////////////////////////////////////
  // Product accumulates per step; a serial divider keeps the quotient
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      acc_r <= 64'sh0;
      dvd_r <= 64'h0;
      quo_r <= 64'h0;
      rem_r <= 33'h0;
      neg_r <= 1'b0;
      bit_r <= 7'h0;
      cmdPos <= 32'h0;
    end else if (clkEn) begin
      if (stepValid) begin
        if (stepDir) acc_r <= acc_r + $signed({32'h0, numer});
        else acc_r <= acc_r - $signed({32'h0, numer});
      end
      if (bit_r == 7'h0) begin
        neg_r <= acc_r[63];
        dvd_r <= acc_r[63] ? (64'h0 - acc_r) : acc_r;
        rem_r <= 33'h0;
        quo_r <= 64'h0;
        bit_r <= 7'h40;
      end else begin
        rem_r <= remGe ? (remSh - {1'b0, denom}) : remSh;
        quo_r <= quoDone;
        dvd_r <= {dvd_r[62:0], 1'b0};
        bit_r <= bit_r - 7'h1;
        if (bit_r == 7'h1) cmdPos <= neg_r ? (32'h0 - quoDone[31:0]) : quoDone[31:0];
      end
    end
  end
endmodule
`default_nettype wire

// file: logic/smpg_pulse_decode.v
`timescale 1ns/1ns
`default_nettype none
`include "smpg_consts.vh"
module smpg_pulse_decode #(
  parameter FILT_W = 4
) (
  // Clock and control
  input wire core_clk,
  input wire rstn,
  input wire clkEn,
  // Synchronised pulse pins and format
  input wire pinA,
  input wire pinB,
  input wire [3:0] pulseType,
  input wire invertLogic,
  input wire [FILT_W-1:0] filtWidth,
  // Count increments
  output reg stepValid,
  output reg stepDir
);
  wire [1:0] raw = {pinB, pinA} ^ {2{invertLogic}};
  reg [1:0] filt_r;
  reg [1:0] prev_r;
  reg [FILT_W-1:0] cnt_r [0:1];
  integer i;
  ////////////////////////////////////////////////////////////////
  // Glitch filter: a level must hold filtWidth+1 cycles to pass
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      filt_r <= 2'h0;
      prev_r <= 2'h0;
      for (i = 0; i < 2; i = i + 1) cnt_r[i] <= {FILT_W{1'b0}};
    end else if (clkEn) begin
      prev_r <= filt_r;
      for (i = 0; i < 2; i = i + 1) begin
        if (raw[i] == filt_r[i]) cnt_r[i] <= {FILT_W{1'b0}};
        else if (cnt_r[i] >= filtWidth) begin
          filt_r[i] <= raw[i];
          cnt_r[i] <= {FILT_W{1'b0}};
        end else cnt_r[i] <= cnt_r[i] + 1'b1;
      end
    end
  end
  ////////////////////////////////////////////////////////////////
  // Edge decode into signed unit steps
  wire [1:0] rise = filt_r & ~prev_r;
  wire [1:0] chg = filt_r ^ prev_r;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      stepValid <= 1'b0;
      stepDir <= 1'b0;
    end else if (clkEn) begin
      case (pulseType)
        `SMPG_PTYPE_PDIR: begin
          stepValid <= rise[0];
          stepDir <= filt_r[1];
        end
        `SMPG_PTYPE_CWCCW: begin
          stepValid <= rise[0] ^ rise[1];
          stepDir <= rise[0];
        end
        `SMPG_PTYPE_QUAD: begin
          stepValid <= chg[0] ^ chg[1];
          stepDir <= filt_r[0] ^ prev_r[1];
        end
        default: begin
          stepValid <= 1'b0;
          stepDir <= 1'b0;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: logic/smpg_top.v
// Decided for this implementation: register access over APB.
`timescale 1ns/1ns
`default_nettype none
`include "smpg_consts.vh"
module smpg_top #(
  parameter CMD_W = 16
) (
  // Clock, reset, enable
  input wire core_clk,
  input wire resetn,
  input wire clkEn,
  // APB slave
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Digital input pins
  input wire servoOnIn,
  input wire pulseInhibitIn,
  input wire gearSel0In,
  input wire gearSel1In,
  input wire cmdSel0In,
  input wire cmdSel1In,
  input wire modeSwitchIn,
  input wire seqTriggerIn,
  input wire homeDoneIn,
  // Pulse pins, main and alternate source
  input wire pulseAIn,
  input wire pulseBIn,
  input wire pulseAAltIn,
  input wire pulseBAltIn,
  // Analog command from the converter, same clock
  input wire [CMD_W-1:0] analogCmd,
  // Mode and command outputs
  output reg posModeActive,
  output reg spdModeActive,
  output reg trqModeActive,
  output reg seqModeActive,
  output reg [CMD_W-1:0] speedCmd,
  output reg [CMD_W-1:0] torqueCmd,
  output reg [31:0] posCmd,
  output reg motorLock,
  output reg homeReq,
  output reg seqRun
);
  localparam SEQ_IDLE = 3'b001;
  localparam SEQ_HOME = 3'b010;
  localparam SEQ_RUN = 3'b100;
  localparam NPIN = 13;

  ////////////////////////////////////////////////////////////////
  // Reset release and pin synchronisers
  reg [1:0] rstSync_r;
  wire rstn = rstSync_r[1];
  always @(posedge core_clk or negedge resetn) begin
    if (!resetn) rstSync_r <= 2'h0;
    else rstSync_r <= {rstSync_r[0], 1'b1};
  end

  reg [NPIN-1:0] pinMeta_r;
  reg [NPIN-1:0] pin_r;
  wire [NPIN-1:0] pinRaw = {pulseBAltIn, pulseAAltIn, pulseBIn, pulseAIn, homeDoneIn,
    seqTriggerIn, modeSwitchIn, cmdSel1In, cmdSel0In, gearSel1In, gearSel0In,
    pulseInhibitIn, servoOnIn};
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pinMeta_r <= {NPIN{1'b0}};
      pin_r <= {NPIN{1'b0}};
    end else if (clkEn) begin
      pinMeta_r <= pinRaw;
      pin_r <= pinMeta_r;
    end
  end
  wire servoOn = pin_r[0];
  wire inhibitPin = pin_r[1];
  wire [1:0] gearSel = pin_r[3:2];
  wire [1:0] cmdSel = pin_r[5:4];
  wire modeSwitch = pin_r[6];
  wire seqTrigger = pin_r[7];
  wire homeDone = pin_r[8];

  ////////////////////////////////////////////////////////////////
  // Register file
  reg [3:0] modeSetting_r;
  reg [3:0] activeMode_r;
  reg [15:0] pulseFmt_r;
  reg [31:0] gearNum_r [0:3];
  reg [31:0] gearDen_r;
  reg [CMD_W-1:0] spdReg_r [0:2];
  reg [CMD_W-1:0] trqReg_r [0:2];
  reg [3:0] smoothK_r;
  reg [2:0] diAssign_r;
  reg [2:0] seqState_r;
  reg seqTrigPrev_r;
  reg signed [31:0] filtPos_r;
  integer k;

  wire inhibitAssigned = diAssign_r[0];
  wire gearSelAssigned = diAssign_r[1];
  wire fixedSetting = diAssign_r[2];

  wire [7:0] regIdx = paddr[9:2];
  wire setupPh = psel & ~penable;
  wire accessWr = psel & penable & pwrite & pready;

  function [31:0] fitCmd;
    input [CMD_W-1:0] v;
    begin
      fitCmd = {{(32-CMD_W){1'b0}}, v};
    end
  endfunction

  function inRange;
    input [31:0] v;
    input [31:0] hi;
    begin
      inRange = (v != 32'h0) && (v <= hi);
    end
  endfunction

  // Decode of an access: mapped, refused, read value
  reg mapped;
  reg refused;
  reg [31:0] rdVal;
  always @* begin
    mapped = 1'b1;
    refused = 1'b0;
    rdVal = 32'h0;
    case (regIdx)
      `SMPG_IDX_MODE: rdVal = {28'h0, modeSetting_r};
      `SMPG_IDX_PULSE_FMT: begin
        rdVal = {16'h0, pulseFmt_r};
        refused = pwrite & (servoOn | (pwdata[15:0] > `SMPG_PULSE_FMT_MAX));
      end
      `SMPG_IDX_GEAR_NUM1: begin
        rdVal = gearNum_r[0];
        refused = pwrite & ~inRange(pwdata, `SMPG_GEAR_NUM_MAX);
      end
      `SMPG_IDX_GEAR_DEN: begin
        rdVal = gearDen_r;
        refused = pwrite & (servoOn | ~inRange(pwdata, `SMPG_GEAR_DEN_MAX));
      end
      `SMPG_IDX_SPD_CMD1: rdVal = fitCmd(spdReg_r[0]);
      `SMPG_IDX_SPD_CMD1 + 8'h1: rdVal = fitCmd(spdReg_r[1]);
      `SMPG_IDX_SPD_CMD1 + 8'h2: rdVal = fitCmd(spdReg_r[2]);
      `SMPG_IDX_TRQ_CMD1: rdVal = fitCmd(trqReg_r[0]);
      `SMPG_IDX_TRQ_CMD1 + 8'h1: rdVal = fitCmd(trqReg_r[1]);
      `SMPG_IDX_TRQ_CMD1 + 8'h2: rdVal = fitCmd(trqReg_r[2]);
      `SMPG_IDX_GEAR_NUM2, `SMPG_IDX_GEAR_NUM2 + 8'h1, `SMPG_IDX_GEAR_NUM2 + 8'h2: begin
        rdVal = gearNum_r[regIdx[1:0] + 2'h1];
        refused = pwrite & ~inRange(pwdata, `SMPG_GEAR_NUM_MAX);
      end
      `SMPG_IDX_SMOOTH: rdVal = {28'h0, smoothK_r};
      `SMPG_IDX_DI_ASSIGN: rdVal = {29'h0, diAssign_r};
      `SMPG_IDX_STATUS: begin
        rdVal = {13'h0, seqState_r, activeMode_r, 2'h0, motorLock, pin_r[8:0]};
        refused = pwrite;
      end
      `SMPG_IDX_POS_CMD: begin
        rdVal = posCmd;
        refused = pwrite;
      end
      default: mapped = 1'b0;
    endcase
    if (paddr[11:10] != 2'h0 || paddr[1:0] != 2'h0) mapped = 1'b0;
  end

  ////////////////////////////////////////////////////////////////
  // APB answer: one access cycle, answer prepared in setup
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      prdata <= 32'h0;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (clkEn) begin
      pready <= setupPh;
      pslverr <= setupPh & (~mapped | refused);
      if (setupPh && !pwrite) prdata <= mapped ? rdVal : 32'h0;
    end
  end

  wire wrOk = accessWr & ~pslverr;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      modeSetting_r <= `SMPG_RST_MODE;
      pulseFmt_r <= `SMPG_RST_PULSE_FMT;
      gearDen_r <= `SMPG_RST_GEAR;
      smoothK_r <= `SMPG_RST_SMOOTH;
      diAssign_r <= `SMPG_RST_DI_ASSIGN;
      for (k = 0; k < 4; k = k + 1) gearNum_r[k] <= `SMPG_RST_GEAR;
      for (k = 0; k < 3; k = k + 1) begin
        spdReg_r[k] <= {CMD_W{1'b0}};
        trqReg_r[k] <= {CMD_W{1'b0}};
      end
    end else if (clkEn && wrOk) begin
      case (regIdx)
        `SMPG_IDX_MODE: modeSetting_r <= pwdata[3:0];
        `SMPG_IDX_PULSE_FMT: pulseFmt_r <= pwdata[15:0];
        `SMPG_IDX_GEAR_NUM1: gearNum_r[0] <= pwdata;
        `SMPG_IDX_GEAR_DEN: gearDen_r <= pwdata;
        `SMPG_IDX_SPD_CMD1: spdReg_r[0] <= pwdata[CMD_W-1:0];
        `SMPG_IDX_SPD_CMD1 + 8'h1: spdReg_r[1] <= pwdata[CMD_W-1:0];
        `SMPG_IDX_SPD_CMD1 + 8'h2: spdReg_r[2] <= pwdata[CMD_W-1:0];
        `SMPG_IDX_TRQ_CMD1: trqReg_r[0] <= pwdata[CMD_W-1:0];
        `SMPG_IDX_TRQ_CMD1 + 8'h1: trqReg_r[1] <= pwdata[CMD_W-1:0];
        `SMPG_IDX_TRQ_CMD1 + 8'h2: trqReg_r[2] <= pwdata[CMD_W-1:0];
        `SMPG_IDX_GEAR_NUM2, `SMPG_IDX_GEAR_NUM2 + 8'h1, `SMPG_IDX_GEAR_NUM2 + 8'h2:
          gearNum_r[regIdx[1:0] + 2'h1] <= pwdata;
        `SMPG_IDX_SMOOTH: smoothK_r <= pwdata[3:0];
        `SMPG_IDX_DI_ASSIGN: diAssign_r <= pwdata[2:0];
        default: ;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////
  // Mode selection
  // The stored mode only reaches the control path while the servo is off,
  // so a running axis changes mode only through modeSwitch in modes 5 to 7.
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) activeMode_r <= `SMPG_RST_MODE;
    else if (clkEn && !servoOn) activeMode_r <= modeSetting_r;
  end

  // Returns {seq, torque, speed, position}
  function [3:0] modeKind;
    input [3:0] mode;
    input sw;
    begin
      case (mode)
        `SMPG_MODE_POS: modeKind = 4'h1;
        `SMPG_MODE_SPD: modeKind = 4'h2;
        `SMPG_MODE_TRQ: modeKind = 4'h4;
        `SMPG_MODE_SPD_INT: modeKind = 4'h2;
        `SMPG_MODE_TRQ_INT: modeKind = 4'h4;
        `SMPG_MODE_SEQ: modeKind = 4'h8;
        `SMPG_MODE_PS: modeKind = sw ? 4'h2 : 4'h1;
        `SMPG_MODE_PT: modeKind = sw ? 4'h4 : 4'h1;
        `SMPG_MODE_ST: modeKind = sw ? 4'h4 : 4'h2;
        default: modeKind = 4'h0;
      endcase
    end
  endfunction

  wire [3:0] kind = modeKind(activeMode_r, modeSwitch);
  wire noAnalog = (activeMode_r == `SMPG_MODE_SPD_INT) || (activeMode_r == `SMPG_MODE_TRQ_INT);

  // Command source: 00 analog (or zero without analog), else internal register
  function [CMD_W-1:0] pickCmd;
    input [1:0] sel;
    input analogOff;
    input [CMD_W-1:0] ana;
    input [CMD_W-1:0] r1;
    input [CMD_W-1:0] r2;
    input [CMD_W-1:0] r3;
    begin
      case (sel)
        2'h1: pickCmd = r1;
        2'h2: pickCmd = r2;
        2'h3: pickCmd = r3;
        default: pickCmd = analogOff ? {CMD_W{1'b0}} : ana;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////
  // Position command path
  wire useAlt = pulseFmt_r[`SMPG_FMT_SRC_BIT];
  wire stepValid;
  wire stepDir;
  smpg_pulse_decode #(
    .FILT_W(4)
  ) uDecode (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .pinA(useAlt ? pin_r[11] : pin_r[9]),
    .pinB(useAlt ? pin_r[12] : pin_r[10]),
    .pulseType(pulseFmt_r[`SMPG_FMT_TYPE_LSB +: 4]),
    .invertLogic(pulseFmt_r[`SMPG_FMT_LOGIC_BIT]),
    .filtWidth(pulseFmt_r[`SMPG_FMT_FILT_LSB +: 4]),
    .stepValid(stepValid),
    .stepDir(stepDir)
  );

  wire inhibitOn = inhibitAssigned & inhibitPin;
  wire countEn = stepValid & kind[0] & servoOn & ~inhibitOn;
  wire [1:0] numIdx = gearSelAssigned ? gearSel : 2'h0;
  wire [31:0] scaledPos;
  smpg_gear_scale uGear (
    .core_clk(core_clk),
    .rstn(rstn),
    .clkEn(clkEn),
    .stepValid(countEn),
    .stepDir(stepDir),
    .numer(gearNum_r[numIdx]),
    .denom(gearDen_r),
    .cmdPos(scaledPos)
  );

  // First-order smoothing: move by difference over 2^k, at least one count
  wire signed [32:0] posDiff = $signed({scaledPos[31], scaledPos}) - $signed({filtPos_r[31], filtPos_r});
  wire signed [32:0] posStep = posDiff >>> smoothK_r;
  wire signed [32:0] posStepMin = (posStep == 33'sh0 && posDiff != 33'sh0) ?
    (posDiff[32] ? -33'sh1 : 33'sh1) : posStep;
  wire [32:0] posSum = $signed({filtPos_r[31], filtPos_r}) + posStepMin;
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) filtPos_r <= 32'sh0;
    else if (clkEn) filtPos_r <= $signed(posSum[31:0]);
  end

  ////////////////////////////////////////////////////////////////
  // Motion sequence start: origin return then run
  reg [2:0] seqState_nxt;
  wire trigEdge = seqTrigger & ~seqTrigPrev_r;
  always @* begin
    seqState_nxt = seqState_r;
    case (seqState_r)
      SEQ_IDLE: if (kind[3] && servoOn && trigEdge) seqState_nxt = SEQ_HOME;
      SEQ_HOME: if (!kind[3] || !servoOn) seqState_nxt = SEQ_IDLE;
        else if (homeDone) seqState_nxt = SEQ_RUN;
      SEQ_RUN: if (!kind[3] || !servoOn) seqState_nxt = SEQ_IDLE;
      default: seqState_nxt = SEQ_IDLE;
    endcase
  end

  ////////////////////////////////////////////////////////////////
  // Output registers
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      seqState_r <= SEQ_IDLE;
      seqTrigPrev_r <= 1'b0;
      posModeActive <= 1'b0;
      spdModeActive <= 1'b0;
      trqModeActive <= 1'b0;
      seqModeActive <= 1'b0;
      speedCmd <= {CMD_W{1'b0}};
      torqueCmd <= {CMD_W{1'b0}};
      posCmd <= 32'h0;
      motorLock <= 1'b0;
      homeReq <= 1'b0;
      seqRun <= 1'b0;
    end else if (clkEn) begin
      seqState_r <= seqState_nxt;
      seqTrigPrev_r <= seqTrigger;
      posModeActive <= kind[0];
      spdModeActive <= kind[1];
      trqModeActive <= kind[2];
      seqModeActive <= kind[3];
      speedCmd <= kind[1] ? pickCmd(cmdSel, noAnalog | fixedSetting, analogCmd,
        spdReg_r[0], spdReg_r[1], spdReg_r[2]) : {CMD_W{1'b0}};
      torqueCmd <= kind[2] ? pickCmd(cmdSel, noAnalog | fixedSetting, analogCmd,
        trqReg_r[0], trqReg_r[1], trqReg_r[2]) : {CMD_W{1'b0}};
      posCmd <= filtPos_r;
      motorLock <= kind[0] & servoOn & inhibitOn;
      homeReq <= seqState_nxt == SEQ_HOME;
      seqRun <= seqState_nxt == SEQ_RUN;
    end
  end
endmodule
`default_nettype wire

// file: sim/servo_mode_pulse_gear_bench.sv
`timescale 1ns/1ns
`default_nettype none
`include "smpg_consts.vh"
module servo_mode_pulse_gear_bench;
  logic core_clk = 0, resetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0, prdata, posCmd;
  logic pready, pslverr, servoOn = 0, inhibit = 0, gSel0 = 0, sel0 = 0, sel1 = 0, modeSw = 0;
  logic gSel1 = 0, trig = 0, home = 0, homeReq, seqRun;
  logic pA, pB, start = 0, up = 1, busy;
  logic [15:0] analog = 16'h0ABC, speedCmd, torqueCmd;
  logic [3:0] kinds;
  logic motorLock;
  int failures = 0, cmp_count = 0;
  // {switch, mode, pos/spd/trq/seq}
  localparam logic [8:0] MT [13] = '{9'h008, 9'h014, 9'h022, 9'h084, 9'h092, 9'h0A1, 9'h058,
    9'h068, 9'h074, 9'h030, 9'h154, 9'h162, 9'h172};
  always #10 core_clk = ~core_clk;
  smpg_top smpg_top_i (.core_clk(core_clk), .resetn(resetn), .clkEn(1'b1), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .servoOnIn(servoOn), .pulseInhibitIn(inhibit),
    .gearSel0In(gSel0), .gearSel1In(gSel1), .cmdSel0In(sel0), .cmdSel1In(sel1),
    .modeSwitchIn(modeSw), .seqTriggerIn(trig), .homeDoneIn(home), .pulseAIn(pA), .pulseBIn(pB),
    .pulseAAltIn(1'b0), .pulseBAltIn(1'b0), .analogCmd(analog),
    .posModeActive(kinds[3]), .spdModeActive(kinds[2]), .trqModeActive(kinds[1]),
    .seqModeActive(kinds[0]), .speedCmd(speedCmd), .torqueCmd(torqueCmd), .posCmd(posCmd),
    .motorLock(motorLock), .homeReq(homeReq), .seqRun(seqRun));
  smpg_ctrl_model smpg_ctrl_model_i (.core_clk(core_clk), .start(start), .count(8'h04),
    .up(up), .pulseA(pA), .pulseB(pB), .busy(busy));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] idx, input logic [31:0] d,
    input logic [31:0] exp, input logic err);
    @(posedge core_clk);
    psel <= 1;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1;
    do @(posedge core_clk); while (pready !== 1'b1);
    if (!w)
      chk(prdata, exp, "read data");
    chk({31'd0, pslverr}, {31'd0, err}, "error flag");
    psel <= 0;
    penable <= 0;
  endtask
  task automatic settle();
    repeat (8) @(posedge core_clk);
  endtask
  task automatic pulses(input logic dir);
    up <= dir;
    start <= 1;
    @(posedge core_clk);
    start <= 0;
    @(posedge core_clk);
    while (busy) @(posedge core_clk);
    repeat (300) @(posedge core_clk);
  endtask
  task automatic stop_test();
    $display("failures=%0d comparisons=%0d", failures, cmp_count);
    if (failures == 0 && cmp_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    stop_test();
  end
  initial begin
    repeat (8) @(posedge core_clk);
    resetn <= 1;
    repeat (3) @(posedge core_clk);
    apb(0, `SMPG_IDX_PULSE_FMT, 0, 32'h2, 0);
    apb(0, `SMPG_IDX_GEAR_NUM1, 0, 32'h1, 0);
    apb(0, `SMPG_IDX_GEAR_DEN, 0, 32'h1, 0);
    apb(0, 8'h10, 0, 32'h0, 1);
    apb(1, `SMPG_IDX_STATUS, 32'h1, 0, 1);
    servoOn <= 1;
    settle();
    apb(1, `SMPG_IDX_PULSE_FMT, 32'h2, 0, 1);
    apb(1, `SMPG_IDX_GEAR_DEN, 32'h5, 0, 1);
    servoOn <= 0;
    settle();
    apb(1, `SMPG_IDX_PULSE_FMT, 32'h1143, 0, 1);
    apb(1, `SMPG_IDX_PULSE_FMT, 32'h1142, 0, 0);
    apb(0, `SMPG_IDX_PULSE_FMT, 0, 32'h1142, 0);
    apb(1, `SMPG_IDX_PULSE_FMT, 32'h2, 0, 0);
    apb(1, `SMPG_IDX_GEAR_DEN, 32'h0, 0, 1);
    apb(1, `SMPG_IDX_GEAR_DEN, 32'h80000000, 0, 1);
    apb(1, `SMPG_IDX_GEAR_NUM1, 32'h0, 0, 1);
    apb(1, `SMPG_IDX_GEAR_NUM1, 32'h04000000, 0, 1);
    foreach (MT[i]) begin
      modeSw <= MT[i][8];
      apb(1, `SMPG_IDX_MODE, {28'd0, MT[i][7:4]}, 0, 0);
      settle();
      chk({28'd0, kinds}, {28'd0, MT[i][3:0]}, "mode kinds");
    end
    modeSw <= 0;
    for (int r = 0; r < 3; r++) begin
      apb(1, `SMPG_IDX_SPD_CMD1 + 8'(r), 32'h111 * (r + 1), 0, 0);
      apb(1, `SMPG_IDX_TRQ_CMD1 + 8'(r), 32'h444 * (r + 1), 0, 0);
    end
    apb(1, `SMPG_IDX_MODE, 32'h1, 0, 0);
    for (int s = 0; s < 4; s++) begin
      {sel1, sel0} <= 2'(s);
      settle();
      chk({16'd0, speedCmd}, s == 0 ? 32'h0ABC : 32'h111 * s, "speed source");
    end
    apb(1, `SMPG_IDX_MODE, 32'h9, 0, 0);
    settle();
    chk({16'd0, torqueCmd}, 32'hCCC, "torque internal");
    {sel1, sel0} <= 2'b00;
    apb(1, `SMPG_IDX_MODE, 32'h8, 0, 0);
    settle();
    chk({16'd0, speedCmd}, 32'h0, "analog ignored");
    apb(1, `SMPG_IDX_MODE, 32'h0, 0, 0);
    apb(1, `SMPG_IDX_GEAR_NUM1, 32'h3, 0, 0);
    apb(1, `SMPG_IDX_GEAR_NUM2, 32'h5, 0, 0);
    apb(1, `SMPG_IDX_GEAR_DEN, 32'h2, 0, 0);
    apb(1, `SMPG_IDX_DI_ASSIGN, 32'h1, 0, 0);
    gSel0 <= 1;
    servoOn <= 1;
    settle();
    pulses(1);
    chk(posCmd, 32'd6, "gear 4*3/2");
    inhibit <= 1;
    settle();
    chk({31'd0, motorLock}, 32'd1, "lock on");
    pulses(1);
    chk(posCmd, 32'd6, "inhibited");
    inhibit <= 0;
    pulses(0);
    chk(posCmd, 32'd0, "down count");
    apb(1, `SMPG_IDX_GEAR_NUM2 + 8'h2, 32'h7, 0, 0);
    apb(1, `SMPG_IDX_DI_ASSIGN, 32'h3, 0, 0);
    gSel1 <= 1;
    settle();
    pulses(1);
    chk(posCmd, 32'd14, "gear select 4*7/2");
    servoOn <= 0;
    settle();
    apb(1, `SMPG_IDX_MODE, 32'hA, 0, 0);
    settle();
    servoOn <= 1;
    settle();
    trig <= 1;
    settle();
    chk({30'd0, homeReq, seqRun}, 32'h2, "origin return");
    home <= 1;
    settle();
    chk({30'd0, homeReq, seqRun}, 32'h1, "sequence run");
    servoOn <= 0;
    settle();
    chk({30'd0, homeReq, seqRun}, 32'h0, "sequence stop");
    stop_test();
  end
endmodule
`default_nettype wire

// file: sim/smpg_ctrl_model.sv
`timescale 1ns/1ns
`default_nettype none
module smpg_ctrl_model (
  // Clock and request
  input wire logic core_clk,
  input wire logic start,
  input wire logic [7:0] count,
  input wire logic up,
  // Pulse pins
  output logic pulseA,
  output logic pulseB,
  output logic busy
);
  logic [7:0] left;
  logic [3:0] tick;
  initial begin
    pulseA = 1'b0;
    pulseB = 1'b0;
    busy = 1'b0;
    left = 8'h00;
    tick = 4'h0;
  end
  // Pulse on A, direction level on B; 16-cycle period stays below the top rate
  always @(posedge core_clk) begin
    if (start && !busy) begin
      busy <= 1'b1;
      left <= count;
      tick <= 4'h0;
      pulseB <= up;
    end else if (busy) begin
      tick <= tick + 4'h1;
      if (tick == 4'h7)
        pulseA <= 1'b1;
      if (tick == 4'hF) begin
        pulseA <= 1'b0;
        left <= left - 8'h01;
        busy <= (left != 8'h01);
      end
    end
  end
endmodule
`default_nettype wire

// file: sim/smpg_top_asserts.sv
`timescale 1ns/1ns
`default_nettype none
module smpg_top_asserts #(
  parameter CMD_W = 16
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic clkEn,
  // APB
  input wire logic [11:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic pready,
  input wire logic pslverr,
  // Mode and command outputs
  input wire logic posModeActive,
  input wire logic spdModeActive,
  input wire logic trqModeActive,
  input wire logic seqModeActive,
  input wire logic [CMD_W-1:0] speedCmd,
  input wire logic [CMD_W-1:0] torqueCmd,
  input wire logic motorLock,
  input wire logic homeReq,
  input wire logic seqRun
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);
  a_ready_one: assert property (psel && !penable && clkEn |=> pready && penable)
    else $error("pready late");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_ready: assert property (pslverr |-> pready)
    else $error("pslverr alone");
  a_unmapped_err: assert property (psel && !penable && paddr[9:2] == 8'h10 |=> pslverr)
    else $error("unmapped accepted");
  a_status_ro: assert property (psel && !penable && pwrite && paddr[9:2] == 8'h38 |=> pslverr)
    else $error("status write accepted");
  a_kind_single: assert property ($onehot0({posModeActive, spdModeActive, trqModeActive, seqModeActive}))
    else $error("two kinds active");
  a_spd_idle: assert property (!spdModeActive |-> speedCmd == '0)
    else $error("speed cmd leaks");
  a_trq_idle: assert property (!trqModeActive |-> torqueCmd == '0)
    else $error("torque cmd leaks");
  a_lock_pos: assert property (motorLock |-> posModeActive)
    else $error("lock outside position");
  a_seq_kind: assert property (homeReq || seqRun |-> seqModeActive)
    else $error("sequence outside mode");
endmodule
bind smpg_top smpg_top_asserts #(.CMD_W(CMD_W)) smpg_top_asserts_i (
  .core_clk(core_clk), .resetn(resetn), .clkEn(clkEn), .paddr(paddr), .psel(psel),
  .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
  .posModeActive(posModeActive), .spdModeActive(spdModeActive), .trqModeActive(trqModeActive),
  .seqModeActive(seqModeActive), .speedCmd(speedCmd), .torqueCmd(torqueCmd),
  .motorLock(motorLock), .homeReq(homeReq), .seqRun(seqRun));
`default_nettype wire
